/* File: verilog/hlsd_top.v */
// Strap decoder: captures switch banks once after power-on reset and
// drives console link settings, start mode, interface choice, ISA window.
// Assumes switches are pins from outside the clock domain.
// Operation
// - Three second-bank switches pick 2400, 4800, 9600, 19200 or 38400 baud, 9600 at shipment.
// - Second-bank switch four picks one or two stop bits, five seven or eight data bits, six parity.
// - Second-bank switch seven picks parity sense and is ignored without parity.
// - Second-bank switch eight off gives RTS/CTS, on gives X-ON/X-OFF.
// - First-bank switch four off gives cold start, on gives automatic warm start.
// - First-bank switches seven and eight pick console, LAN, or PC board.
// - All settings are captured only at power-on.
// - The host board claims a 16 kbyte window at C0000 plus setting times 4000.
// - Rotary settings C to F map no window.
// - Factory rotary setting 4 maps D0000 to D3FFF.
`timescale 1ns/1ns
`include "hlsd_defs.vh"
module hlsd_top #(
  parameter SETTLE_CYCLES = 4
) (
  input wire core_clk,
  input wire rst,
  input wire [7:0] first_switch_bank,
  input wire [7:0] second_switch_bank,
  input wire [3:0] rotary_switch,
  input wire [19:0] isa_addr,
  input wire isa_mem_cycle,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata_r,
  output reg straps_valid_r,
  output reg [15:0] baud_rate_r,
  output reg [2:0] baud_code_r,
  output reg two_stop_bits_r,
  output reg eight_data_bits_r,
  output reg parity_enable_r,
  output reg parity_sense_r,
  output reg xon_xoff_flow_r,
  output reg warm_start_r,
  output reg [1:0] host_if_r,
  output reg unused_switch_on_r,
  output wire window_valid,
  output wire [19:0] window_base,
  output wire isa_select
);
  // ****************************************
  // Register map
  // ****************************************
  // Word 0, read only: console link image
  //   [7:0] second bank image, [15:8] upper byte of the rate, [16] straps valid
  // Word 4, read only: start and interface image
  //   [7:0] first bank image, [9:8] interface code
  // Word 8, read only: memory window
  //   [19:0] window base, [23:20] rotary image, [24] window valid
  // Word C, read and write: scratch word for software
  // Writes to the read-only words are dropped; unmapped reads return zero
  localparam [3:0] ADDR_SERIAL = `HLSD_ADDR_SERIAL;
  localparam [3:0] ADDR_FIRST = `HLSD_ADDR_FIRST;
  localparam [3:0] ADDR_WINDOW = `HLSD_ADDR_WINDOW;
  localparam [3:0] ADDR_SCRATCH = `HLSD_ADDR_SCRATCH;

  // ****************************************
  // Capture sequencer states
  // ****************************************
  // Capture timeline after reset release:
  //   edges 1 and 2 fill the synchronisers while the settle counter runs
  //   the settle counter holds off capture until SETTLE_CYCLES plus one edges have passed
  //   one edge in capture latches both banks and the rotary setting
  //   one edge later the decoded settings and straps valid follow
  //   on that same edge the memory window follows
  // Until then the decoded settings show the factory setting, the window from the first edge after reset release
  // A switch moved later has no effect until the next reset
  localparam [1:0] ST_SETTLE = 2'h0;
  localparam [1:0] ST_CAPTURE = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;

  // Synchronised pins, sequencer, latched images, register port state
  wire [7:0] first_sync;
  wire [7:0] second_sync;
  wire [3:0] rotary_sync;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] settle_r;
  reg [7:0] serial_r;
  reg [7:0] first_r;
  reg [3:0] rotary_r;
  reg [31:0] scratch_r;
  reg [31:0] rdata_nxt;

  // Rate field of the second bank image
  function [2:0] baud_field;
    input [7:0] image;
    begin
      baud_field = image[`HLSD_BAUD_MSB:`HLSD_BAUD_LSB];
    end
  endfunction

  // Baud code to rate
  function [15:0] baud_of;
    input [2:0] code;
    begin
      case (code)
        3'h0: baud_of = `HLSD_BAUD_2400;
        3'h1: baud_of = `HLSD_BAUD_4800;
        3'h2: baud_of = `HLSD_BAUD_9600;
        3'h3: baud_of = `HLSD_BAUD_19200;
        3'h4: baud_of = `HLSD_BAUD_38400;
        default: baud_of = `HLSD_BAUD_9600;
      endcase
    end
  endfunction

  // Interface switches to code
  function [1:0] if_of;
    input high;
    input low;
    begin
      case ({high, low})
        2'b00: if_of = `HLSD_IF_CONSOLE;
        2'b01: if_of = `HLSD_IF_LAN;
        2'b11: if_of = `HLSD_IF_PC;
        default: if_of = `HLSD_IF_BAD;
      endcase
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Switch pins are asynchronous to core_clk; each bank goes through its own
  // two-flop synchroniser so that no decode logic sees a metastable level
  // The banks are sampled together but may settle an edge apart; the settle
  // counter covers that skew before anything is latched
  hlsd_sync #(.WIDTH(8)) u_sync_first (
    .core_clk(core_clk),
    .rst(rst),
    .din(first_switch_bank),
    .dout(first_sync)
  );

  hlsd_sync #(.WIDTH(8)) u_sync_second (
    .core_clk(core_clk),
    .rst(rst),
    .din(second_switch_bank),
    .dout(second_sync)
  );

  hlsd_sync #(.WIDTH(4)) u_sync_rotary (
    .core_clk(core_clk),
    .rst(rst),
    .din(rotary_switch),
    .dout(rotary_sync)
  );

  // ****************************************
  // One-shot capture after reset release
  // ****************************************
  // Next state: wait for synchronisers, capture once, then hold forever
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_SETTLE: if (settle_r >= SETTLE_CYCLES[7:0]) state_nxt = ST_CAPTURE;
      ST_CAPTURE: state_nxt = ST_HOLD;
      ST_HOLD: state_nxt = ST_HOLD;
      default: state_nxt = ST_SETTLE;
    endcase
  end

  // Sequencer state
  always @(posedge core_clk or posedge rst) begin
    if (rst)
      state_r <= ST_SETTLE;
    else
      state_r <= state_nxt;
  end

  // Settle counter, runs only while waiting
  always @(posedge core_clk or posedge rst) begin
    if (rst)
      settle_r <= 8'h00;
    else if (state_r == ST_SETTLE)
      settle_r <= settle_r + 8'h01;
  end

  // Latched switch images, written once in the capture state
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      serial_r <= `HLSD_SERIAL_RESET;
      first_r <= `HLSD_FIRST_RESET;
      rotary_r <= `HLSD_ROTARY_RESET;
    end else if (state_r == ST_CAPTURE) begin
      serial_r <= second_sync;
      first_r <= first_sync;
      rotary_r <= rotary_sync;
    end
  end

  // ****************************************
  // Decoded settings
  // ****************************************
  // Console link settings from the second bank image
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      baud_code_r <= 3'h2;
      baud_rate_r <= `HLSD_BAUD_9600;
      two_stop_bits_r <= 1'b0;
      eight_data_bits_r <= 1'b1;
      parity_enable_r <= 1'b0;
      parity_sense_r <= 1'b0;
      xon_xoff_flow_r <= 1'b1;
    end else begin
      baud_code_r <= baud_field(serial_r);
      baud_rate_r <= baud_of(baud_field(serial_r));
      two_stop_bits_r <= serial_r[`HLSD_STOP_BIT];
      eight_data_bits_r <= serial_r[`HLSD_DATA_BIT];
      parity_enable_r <= serial_r[`HLSD_PAR_EN_BIT];
      // Sense bit is forced low while parity is off
      parity_sense_r <= serial_r[`HLSD_PAR_EN_BIT] & serial_r[`HLSD_PAR_SEL_BIT];
      xon_xoff_flow_r <= serial_r[`HLSD_FLOW_BIT];
    end
  end

  // Start mode and host interface from the first bank image
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      warm_start_r <= 1'b0;
      host_if_r <= `HLSD_IF_CONSOLE;
    end else begin
      warm_start_r <= first_r[`HLSD_WARM_BIT];
      host_if_r <= if_of(first_r[`HLSD_IF_HIGH_BIT], first_r[`HLSD_IF_LOW_BIT]);
    end
  end

  // Status flags: capture done, unused switch found on
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      straps_valid_r <= 1'b0;
      unused_switch_on_r <= 1'b0;
    end else begin
      straps_valid_r <= (state_r == ST_HOLD);
      // Unused switches are only reported; the operator must keep them off
      unused_switch_on_r <= |(first_r & `HLSD_UNUSED_MASK);
    end
  end

  // ****************************************
  // ISA window decoder
  // ****************************************
  // The window decoder reads the latched rotary image, never the pin, so the
  // window cannot move under the host after power-on
  // The ISA address and memory-cycle strobe come from logic on core_clk
  hlsd_isa_window u_window (
    .core_clk(core_clk),
    .rst(rst),
    .rotary(rotary_r),
    .isa_addr(isa_addr),
    .isa_mem_cycle(isa_mem_cycle),
    .window_valid_r(window_valid),
    .window_base_r(window_base),
    .isa_select_r(isa_select)
  );

  // ****************************************
  // Register port
  // ****************************************
  // Scratch register, the only writable word
  always @(posedge core_clk or posedge rst) begin
    if (rst)
      scratch_r <= 32'h00000000;
    else if (reg_write && reg_addr == ADDR_SCRATCH)
      scratch_r <= reg_wdata;
  end

  // Read words assembled from the latched images and decoded settings
  wire [31:0] word_serial;
  wire [31:0] word_first;
  wire [31:0] word_window;
  assign word_serial = {15'h0000, straps_valid_r, baud_rate_r[15:8], serial_r};
  assign word_first = {22'h000000, host_if_r, first_r};
  assign word_window = {7'h00, window_valid, rotary_r, window_base};

  // Read mux
  always @* begin
    rdata_nxt = 32'h00000000;
    case (reg_addr)
      ADDR_SERIAL: rdata_nxt = word_serial;
      ADDR_FIRST: rdata_nxt = word_first;
      ADDR_WINDOW: rdata_nxt = word_window;
      ADDR_SCRATCH: rdata_nxt = scratch_r;
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always @(posedge core_clk or posedge rst) begin
    if (rst)
      reg_rdata_r <= 32'h00000000;
    else if (reg_read)
      reg_rdata_r <= rdata_nxt;
    else
      reg_rdata_r <= 32'h00000000;
  end
endmodule // hlsd_top

/* File: include/hlsd_defs.vh */
// Constants for the host link strap decoder: switch fields, codes, window map.
// Assumes inclusion by bare name from the design files.
`ifndef HLSD_DEFS_VH
`define HLSD_DEFS_VH
// ****************************************
// Second bank field positions
// ****************************************
`define HLSD_BAUD_LSB 0
`define HLSD_BAUD_MSB 2
`define HLSD_STOP_BIT 3
`define HLSD_DATA_BIT 4
`define HLSD_PAR_EN_BIT 5
`define HLSD_PAR_SEL_BIT 6
`define HLSD_FLOW_BIT 7
// ****************************************
// First bank field positions
// ****************************************
`define HLSD_WARM_BIT 3
`define HLSD_IF_HIGH_BIT 6
`define HLSD_IF_LOW_BIT 7
`define HLSD_UNUSED_MASK 8'h37
// ****************************************
// Baud rates in bits per second
// ****************************************
`define HLSD_BAUD_2400 16'h0960
`define HLSD_BAUD_4800 16'h12C0
`define HLSD_BAUD_9600 16'h2580
`define HLSD_BAUD_19200 16'h4B00
`define HLSD_BAUD_38400 16'h9600
// ****************************************
// Host interface codes
// ****************************************
`define HLSD_IF_CONSOLE 2'h0
`define HLSD_IF_LAN 2'h1
`define HLSD_IF_PC 2'h2
`define HLSD_IF_BAD 2'h3
// ****************************************
// ISA memory window and switch image reset values
// ****************************************
`define HLSD_WIN_BASE_TOP 6'h30
`define HLSD_WIN_LAST_SET 4'hB
`define HLSD_ROTARY_RESET 4'h4
`define HLSD_SERIAL_RESET 8'h92
`define HLSD_FIRST_RESET 8'h00
// ****************************************
// Register port word offsets
// ****************************************
`define HLSD_ADDR_SERIAL 4'h0
`define HLSD_ADDR_FIRST 4'h4
`define HLSD_ADDR_WINDOW 4'h8
`define HLSD_ADDR_SCRATCH 4'hC
`endif

/* File: verilog/hlsd_sync.v */
// Two-stage synchroniser for a bus of pin levels.
// Assumes the inputs are quasi-static switch levels.
`timescale 1ns/1ns
module hlsd_sync #(
  parameter WIDTH = 8
) (
  input wire core_clk,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // Two flops; the first is read only by the second
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule // hlsd_sync

/* File: verilog/hlsd_isa_window.v */
// ISA memory window decoder for the host board.
// Assumes the rotary setting is latched and stable, address from same clock.
`timescale 1ns/1ns
`include "hlsd_defs.vh"
module hlsd_isa_window (
  input wire core_clk,
  input wire rst,
  input wire [3:0] rotary,
  input wire [19:0] isa_addr,
  input wire isa_mem_cycle,
  output reg window_valid_r,
  output reg [19:0] window_base_r,
  output reg isa_select_r
);
  wire valid_nxt;
  wire [5:0] top_nxt;
  wire hit_nxt;

  // Settings above B map nothing
  assign valid_nxt = (rotary <= `HLSD_WIN_LAST_SET);
  // Base is C0000 plus setting times 4000
  assign top_nxt = `HLSD_WIN_BASE_TOP + {2'h0, rotary};
  // Claim only a matching memory cycle
  assign hit_nxt = isa_mem_cycle && valid_nxt && (isa_addr[19:14] == top_nxt);

  // Registered window and select
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      window_valid_r <= 1'b0;
      window_base_r <= 20'h00000;
      isa_select_r <= 1'b0;
    end else begin
      window_valid_r <= valid_nxt;
      window_base_r <= valid_nxt ? {top_nxt, 14'h0000} : 20'h00000;
      isa_select_r <= hit_nxt;
    end
  end
endmodule // hlsd_isa_window

/* File: testbench/hlsd_checker.sv */
// Checker for the strap decoder: window map, ISA select, decode and hold.
// Assumes binding to hlsd_top; all watched signals share core_clk.
`timescale 1ns/1ns
module hlsd_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic isa_mem_cycle,
  input wire logic [19:0] isa_addr,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata_r,
  input wire logic straps_valid_r,
  input wire logic [15:0] baud_rate_r,
  input wire logic [2:0] baud_code_r,
  input wire logic parity_enable_r,
  input wire logic parity_sense_r,
  input wire logic [1:0] host_if_r,
  input wire logic window_valid,
  input wire logic [19:0] window_base,
  input wire logic isa_select
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Memory cycle inside a settled window
  sequence s_hit;
    isa_mem_cycle && window_valid && isa_addr[19:14] == window_base[19:14];
  endsequence
  // Straps latched and decoded long enough to be final
  sequence s_settled;
    straps_valid_r [*3];
  endsequence
  AST_ISA_HIT: assert property (s_hit ##1 ($stable(window_base) && $stable(window_valid))
    |-> isa_select) else $error("window hit not selected");
  AST_ISA_MISS: assert property (!(isa_mem_cycle && window_valid
    && isa_addr[19:14] == window_base[19:14])
    ##1 ($stable(window_base) && $stable(window_valid)) |-> !isa_select)
    else $error("select outside window");
  AST_WIN_MAP: assert property (window_valid |-> window_base[13:0] == 14'h0000
    && window_base >= 20'hC0000 && window_base <= 20'hEC000) else $error("bad window base");
  AST_WIN_NONE: assert property (!window_valid |-> window_base == 20'h00000)
    else $error("base without window");
  AST_PAR: assert property (parity_sense_r |-> parity_enable_r)
    else $error("parity sense without parity");
  AST_BAUD: assert property (baud_rate_r ==
    (baud_code_r <= 3'h4 ? 16'h0960 << baud_code_r : 16'h2580)) else $error("baud map");
  AST_HOLD: assert property (s_settled |=> straps_valid_r && $stable(baud_code_r)
    && $stable(host_if_r) && $stable(window_base)) else $error("straps changed");
  AST_RDATA: assert property (!$past(reg_read) |-> reg_rdata_r == 32'h00000000)
    else $error("read data without read");
endmodule // hlsd_checker

bind hlsd_top hlsd_checker chk_i (.core_clk(core_clk), .rst(rst),
  .isa_mem_cycle(isa_mem_cycle), .isa_addr(isa_addr), .reg_read(reg_read),
  .reg_rdata_r(reg_rdata_r), .straps_valid_r(straps_valid_r), .baud_rate_r(baud_rate_r),
  .baud_code_r(baud_code_r), .parity_enable_r(parity_enable_r),
  .parity_sense_r(parity_sense_r), .host_if_r(host_if_r), .window_valid(window_valid),
  .window_base(window_base), .isa_select(isa_select));

/* File: testbench/hlsd_isa_host.sv */
// ISA host model: single-cycle memory cycles, scrambled bus while idle.
// Assumes go and addr_in change just after core_clk edges.
`timescale 1ns/1ns
module hlsd_isa_host (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [19:0] addr_in,
  output logic [19:0] isa_addr = 20'h00000,
  output logic isa_mem_cycle = 1'b0
);
  // Only this board decodes on the modelled bus, so no overlap
  always @(posedge core_clk) begin
    isa_mem_cycle <= go;
    isa_addr <= go ? addr_in : ~isa_addr + 20'h00001;
  end
endmodule // hlsd_isa_host

/* File: testbench/hlsd_top_tb.sv */
// Testbench: per-setting reset and capture, hold, ISA window and register port.
// Assumes the design, the checker and the ISA host model are compiled first.
`timescale 1ns/1ns
module hlsd_top_tb;
  logic core_clk = 0, rst = 1, go = 0, reg_write = 0, reg_read = 0;
  logic [7:0] b1 = 8'h00, b2 = 8'h00, e1, e2;
  logic [3:0] rot = 4'h0, reg_addr = 4'h0;
  logic [19:0] go_addr = 20'h00000, isa_addr, base, eb;
  logic [31:0] reg_wdata = 32'h00000000, rd_q, r, seed = 32'h0001133F;
  logic isa_mem_cycle, sv, isel, wv, ts, ed, pe, ps, xf, ws, un;
  logic [15:0] baud, bx;
  bit sel_q[$];
  logic [1:0] hi;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  // ****************************************
  // Clock, timeout, instances
  // ****************************************
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  hlsd_isa_host host (.core_clk(core_clk), .go(go), .addr_in(go_addr),
    .isa_addr(isa_addr), .isa_mem_cycle(isa_mem_cycle));
  hlsd_top #(.SETTLE_CYCLES(1)) uut (.core_clk(core_clk), .rst(rst),
    .first_switch_bank(b1), .second_switch_bank(b2), .rotary_switch(rot),
    .isa_addr(isa_addr), .isa_mem_cycle(isa_mem_cycle), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_r(rd_q),
    .straps_valid_r(sv), .baud_rate_r(baud), .baud_code_r(), .two_stop_bits_r(ts),
    .eight_data_bits_r(ed), .parity_enable_r(pe), .parity_sense_r(ps),
    .xon_xoff_flow_r(xf), .warm_start_r(ws), .host_if_r(hi), .unused_switch_on_r(un),
    .window_valid(wv), .window_base(base), .isa_select(isel));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Decoded straps against the captured switch images
  task automatic st();
    chk(baud, e2[2:0] <= 3'h4 ? 32'h0960 << e2[2:0] : 32'h2580);
    chk({ts, ed, pe}, {e2[3], e2[4], e2[5]});
    chk(ps, e2[5] & e2[6]);
    chk(xf, e2[7]);
    chk(ws, e1[3]);
    chk(hi, e1[6] ? (e1[7] ? 2 : 3) : e1[7]);
    chk({sv, un, wv, base}, {2'b10, eb != 20'h0, eb});
  endtask
  task automatic isa(input logic [19:0] a, input logic e);
    sel_q.push_back(e);
    @(posedge core_clk);
    go <= 1;
    go_addr <= a;
    @(posedge core_clk);
    go <= 0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(isel, sel_q.pop_front());
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_write <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_read <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 0;
    @(negedge core_clk);
    chk(rd_q, e);
  endtask
  // ****************************************
  // Main sequence: every rotary setting and baud code
  // ****************************************
  initial begin
    for (int i = 0; i < 16; i++) begin
      r = xs();
      e2 = {r[7:3], i[2:0]};
      bx = e2[2:0] <= 3'h4 ? 16'h0960 << e2[2:0] : 16'h2580;
      e1 = r[15:8] & ~8'h37;
      eb = (i < 12) ? 20'hC0000 + 20'(i) * 20'h04000 : 20'h00000;
      @(posedge core_clk);
      rst <= 1;
      b1 <= e1;
      b2 <= e2;
      rot <= 4'(i);
      @(negedge core_clk);
      chk({baud, xf, ed, ts, pe}, {16'h2580, 4'b1100});
      repeat (5) @(posedge core_clk);
      rst <= 0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk(base, 20'hD0000);
      chk({pe, ps, ws, baud}, {3'b000, 16'h2580});
      for (int k = 0; k < 40 && sv !== 1'b1; k++) @(negedge core_clk);
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      st();
      @(posedge core_clk);
      b1 <= ~e1;
      b2 <= ~e2;
      rot <= ~rot;
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      st();
      isa({6'h30 + 6'(i), r[29:16]}, i < 12);
      isa({6'h2F, r[29:16]}, 1'b0);
      rd(4'h0, {15'h0000, 1'b1, bx[15:8], e2});
      rd(4'h4, {22'h000000, 2'(e1[6] ? (e1[7] ? 2 : 3) : e1[7]), e1});
      rd(4'h8, {7'h00, i < 12, 4'(i), eb});
    end
    wr(4'hC, r);
    wr(4'h1, ~r);
    rd(4'hC, r);
    rd(4'h1, 32'h00000000);
    end_of_test();
  end
endmodule // hlsd_top_tb
